/* File: logic/reset_strap_pkg.sv */
package reset_strap_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // Strap sample delay after reset release
  localparam int STRAP_DELAY_NS = 1500;
  localparam int STRAP_DELAY_CYC = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_W = 8;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] STRAP_DELAY_CNT = CNT_W'(STRAP_DELAY_CYC);
  localparam logic [STRAP_W-1:0] STRAP_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [1:0] {ST_HELD, ST_WAIT, ST_SAMPLE, ST_RUN} seq_state_t;

  typedef struct packed {
    logic [STRAP_W-1:0] in;
    logic [STRAP_W-1:0] out;
    logic [STRAP_W-1:0] oe;
  } strap_pins_t;

  typedef struct packed {
    seq_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [STRAP_W-1:0] mode;
    logic cfg_start;
    logic ready;
    logic park;
    logic [STRAP_W-1:0] tout;
    logic [STRAP_W-1:0] toe;
  } seq_regs_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } sync_regs_t;
endpackage

/* File: logic/level_sync.sv */
`timescale 1ns/100ps
module level_sync
  import reset_strap_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level
  input wire logic d,
  output logic q
);
  sync_regs_t r_r;
  sync_regs_t r_nxt;

  always_comb begin
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_r <= {INIT, INIT};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.s2;
endmodule

/* File: logic/reset_teststrap_park_control.sv */
`timescale 1ns/100ps
module reset_teststrap_park_control
  import reset_strap_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Control inputs
  input wire logic POWER_ON_RESET_N,
  input wire logic FAST_PARK_N,
  input wire logic MANUFACTURING_TEST_ENABLE,
  input wire logic TEST_ACCESS_RESET_N,
  // Test strap pins
  input wire logic [STRAP_W-1:0] TEST_STRAP_PINS_IN,
  output logic [STRAP_W-1:0] TEST_STRAP_PINS_OUT,
  output logic [STRAP_W-1:0] TEST_STRAP_PINS_OE,
  // Internal test output data
  input wire logic [STRAP_W-1:0] TEST_OUT_DATA,
  // Status towards the core
  output logic CONFIG_START,
  output logic CORE_READY,
  output logic [STRAP_W-1:0] TEST_MODE,
  output logic TEST_HOLD,
  output logic FAST_PARK_REQ
);
  logic por_n_s;
  logic park_n_s;
  seq_regs_t r_r;
  seq_regs_t r_nxt;

  level_sync #(.INIT(1'b0)) u_por_sync (
    .clk(CLOCK),
    .rst(RESET),
    .d(POWER_ON_RESET_N),
    .q(por_n_s)
  );

  // Park sync resets inactive-high so a reset never fakes a park
  level_sync #(.INIT(1'b1)) u_park_sync (
    .clk(CLOCK),
    .rst(RESET),
    .d(FAST_PARK_N),
    .q(park_n_s)
  );

  always_comb begin
    r_nxt = r_r;
    r_nxt.cfg_start = 1'b0;
    if (!por_n_s) begin
      r_nxt.st = ST_HELD;
      r_nxt.cnt = '0;
      r_nxt.mode = STRAP_RESET;
      r_nxt.ready = 1'b0;
      r_nxt.park = 1'b0;
      r_nxt.tout = STRAP_RESET;
      r_nxt.toe = STRAP_RESET;
    end else begin
      case (r_r.st)
        ST_HELD: begin
          r_nxt.st = ST_WAIT;
          r_nxt.cfg_start = 1'b1;
          r_nxt.cnt = CNT_W'(1);
        end
        ST_WAIT: begin
          r_nxt.cnt = r_r.cnt + CNT_W'(1);
          if (r_r.cnt == STRAP_DELAY_CNT - CNT_W'(1)) begin
            r_nxt.st = ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          r_nxt.mode = TEST_STRAP_PINS_IN;
          r_nxt.st = ST_RUN;
          r_nxt.toe = {STRAP_W{1'b1}};
          r_nxt.ready = 1'b1;
        end
        default: begin
          r_nxt.tout = TEST_OUT_DATA;
          r_nxt.park = ~park_n_s;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign CONFIG_START = r_r.cfg_start;
  assign CORE_READY = r_r.ready;
  assign TEST_MODE = r_r.mode;
  assign FAST_PARK_REQ = r_r.park;
  assign TEST_STRAP_PINS_OUT = r_r.tout;
  assign TEST_STRAP_PINS_OE = r_r.toe;
  // Either test input high keeps the core from starting normally
  assign TEST_HOLD = MANUFACTURING_TEST_ENABLE | TEST_ACCESS_RESET_N;

  // Checks watch the synchronised reset, as the sequencer does
  property p_held_quiet;
    @(posedge CLOCK) disable iff (RESET)
    !por_n_s |=> (!r_r.ready && !r_r.park && r_r.toe == '0);
  endproperty
  a_held_quiet: assert property (p_held_quiet) else $error("output active in reset");

  property p_oe_off;
    @(posedge CLOCK) disable iff (RESET)
    (!por_n_s && TEST_STRAP_PINS_OE == '0) |=> TEST_STRAP_PINS_OE == '0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("strap pins driven in reset");

  property p_cfg_start;
    @(posedge CLOCK) disable iff (RESET)
    (por_n_s && r_r.st == ST_HELD) |=> CONFIG_START;
  endproperty
  a_cfg_start: assert property (p_cfg_start) else $error("no config start");

  // Fifteen cycles with reset released: the strap delay at the fixed clock
  property p_strap_time;
    @(posedge CLOCK) disable iff (RESET)
    $rose(CONFIG_START) && por_n_s ##1 por_n_s[*7] ##1 por_n_s[*7]
      |=> TEST_STRAP_PINS_OE == '1;
  endproperty
  a_strap_time: assert property (p_strap_time) else $error("strap sample late");

  property p_not_early;
    @(posedge CLOCK) disable iff (RESET)
    $rose(CONFIG_START)
      |-> (TEST_STRAP_PINS_OE == '0)[*8] ##1 (TEST_STRAP_PINS_OE == '0)[*7];
  endproperty
  a_not_early: assert property (p_not_early) else $error("strap sample early");

  property p_mode_held;
    @(posedge CLOCK) disable iff (RESET)
    (r_r.st == ST_RUN && por_n_s) |=> $stable(TEST_MODE) || !por_n_s;
  endproperty
  a_mode_held: assert property (p_mode_held) else $error("mode changed");

  property p_park;
    @(posedge CLOCK) disable iff (RESET)
    (r_r.st == ST_RUN && por_n_s && !park_n_s) |=> FAST_PARK_REQ || !$past(por_n_s);
  endproperty
  a_park: assert property (p_park) else $error("park missed");

  property p_park_sync;
    @(posedge CLOCK) disable iff (RESET)
    FAST_PARK_N [*3] |=> !FAST_PARK_REQ;
  endproperty
  a_park_sync: assert property (p_park_sync) else $error("park without input");

  property p_cfg_pulse;
    @(posedge CLOCK) disable iff (RESET)
    CONFIG_START |=> !CONFIG_START;
  endproperty
  a_cfg_pulse: assert property (p_cfg_pulse) else $error("config start too long");

  property p_cfg_once;
    @(posedge CLOCK) disable iff (RESET)
    CORE_READY |-> !CONFIG_START;
  endproperty
  a_cfg_once: assert property (p_cfg_once) else $error("config start repeated");

  property p_no_start_low;
    @(posedge CLOCK) disable iff (RESET)
    !por_n_s |=> !CONFIG_START;
  endproperty
  a_no_start_low: assert property (p_no_start_low) else $error("start while in reset");

  property p_held_clear;
    @(posedge CLOCK) disable iff (RESET)
    !por_n_s |=> (TEST_MODE == '0 && TEST_STRAP_PINS_OUT == '0);
  endproperty
  a_held_clear: assert property (p_held_clear) else $error("state kept in reset");

  property p_mode_capture;
    @(posedge CLOCK) disable iff (RESET)
    (r_r.st == ST_SAMPLE && por_n_s) |=> TEST_MODE == $past(TEST_STRAP_PINS_IN);
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("straps not captured");

  // Pins switch to outputs all at once, together with ready
  property p_oe_ready;
    @(posedge CLOCK) disable iff (RESET)
    (TEST_STRAP_PINS_OE == '0 && !CORE_READY) || (TEST_STRAP_PINS_OE == '1 && CORE_READY);
  endproperty
  a_oe_ready: assert property (p_oe_ready) else $error("pin enable mismatch");

  property p_ready_stays;
    @(posedge CLOCK) disable iff (RESET)
    (CORE_READY && por_n_s) |=> CORE_READY;
  endproperty
  a_ready_stays: assert property (p_ready_stays) else $error("ready dropped");

  property p_tout_follow;
    @(posedge CLOCK) disable iff (RESET)
    (r_r.st == ST_RUN && por_n_s) |=> TEST_STRAP_PINS_OUT == $past(TEST_OUT_DATA);
  endproperty
  a_tout_follow: assert property (p_tout_follow) else $error("test output stale");

  property p_park_release;
    @(posedge CLOCK) disable iff (RESET)
    (r_r.st == ST_RUN && por_n_s && park_n_s) |=> !FAST_PARK_REQ;
  endproperty
  a_park_release: assert property (p_park_release) else $error("park stuck");

  // Park is ignored until startup has finished
  property p_no_park_early;
    @(posedge CLOCK) disable iff (RESET)
    r_r.st != ST_RUN |-> !FAST_PARK_REQ;
  endproperty
  a_no_park_early: assert property (p_no_park_early) else $error("park before startup");

  c_start: cover property (@(posedge CLOCK) disable iff (RESET) CONFIG_START);
  c_ready: cover property (@(posedge CLOCK) disable iff (RESET) $rose(CORE_READY));
  c_park: cover property (@(posedge CLOCK) disable iff (RESET) $rose(FAST_PARK_REQ));
  c_mode: cover property (@(posedge CLOCK) disable iff (RESET)
    $rose(CORE_READY) && TEST_MODE != '0);
endmodule

/* File: verif/pmic_model.sv */
`timescale 1ns/100ps
module pmic_model (
  // Clock
  input wire logic clk,
  // Commands from the bench
  input wire logic por_go,
  input wire logic park_go,
  // Lines towards the controller
  output logic por_n,
  output logic park_n,
  output logic mte,
  output logic tar_n
);
  initial begin
    por_n = 1'b0;
    park_n = 1'b1;
    mte = 1'b0;
    tar_n = 1'b0;
  end
  // Release only when told supplies are good
  always @(posedge clk) begin
    por_n <= #1 por_go;
    park_n <= #1 !park_go;
  end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import reset_strap_pkg::*;
  logic clk = 0, rst = 1, por_go = 0, park_go = 0;
  logic por_n, park_n, mte, tar_n, cfg, rdy, hold, preq;
  logic [7:0] ext = 8'h00, tdata = 8'h3c, pin, pout, poe, mode;
  int fails = 0, cmp_count = 0, n;
  always #50 clk = ~clk;
  // Undriven pins take the bench value ext, driven pins show pout
  assign pin = (poe & pout) | (~poe & ext);
  pmic_model pm (.clk(clk), .por_go(por_go), .park_go(park_go), .por_n(por_n),
    .park_n(park_n), .mte(mte), .tar_n(tar_n));
  reset_teststrap_park_control dut (.CLOCK(clk), .RESET(rst), .POWER_ON_RESET_N(por_n),
    .FAST_PARK_N(park_n), .MANUFACTURING_TEST_ENABLE(mte), .TEST_ACCESS_RESET_N(tar_n),
    .TEST_STRAP_PINS_IN(pin), .TEST_STRAP_PINS_OUT(pout), .TEST_STRAP_PINS_OE(poe),
    .TEST_OUT_DATA(tdata), .CONFIG_START(cfg), .CORE_READY(rdy), .TEST_MODE(mode),
    .TEST_HOLD(hold), .FAST_PARK_REQ(preq));
  task complete_run;
    $display("checks %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task step;
    @(posedge clk);
    #1;
  endtask
  task hit(input int k);
    if (k >= 40) begin
      fails++;
      complete_run();
    end
  endtask
  task held;
    por_go = 0;
    park_go = 1;
    ext = 8'h81;
    repeat (5) step;
    chk(poe, 8'h00);
    chk(pin, 8'h81);
    chk(8'({cfg, rdy, preq}), 8'h00);
    chk(mode, 8'h00);
    park_go = 0;
    $display("held test done");
  endtask
  task start(input logic [7:0] s);
    ext = s;
    por_go = 1;
    n = 0;
    while (cfg !== 1'b1 && n < 40) begin
      step;
      n++;
    end
    hit(n);
    step;
    chk(8'(cfg), 8'h00);
    n = 1;
    while (rdy !== 1'b1 && n < 40) begin
      step;
      n++;
    end
    hit(n);
    chk(8'(n), 8'(STRAP_DELAY_CYC));
    chk(poe, 8'hff);
    chk(mode, s);
    ext = ~s;
    repeat (3) step;
    chk(pin, tdata);
    chk(mode, s);
    chk(8'(hold), 8'h00);
    $display("startup test done");
  endtask
  task park;
    park_go = 1;
    step;
    chk(8'(preq), 8'h00);
    n = 1;
    while (preq !== 1'b1 && n < 40) begin
      step;
      n++;
    end
    hit(n);
    chk(8'(n), 8'h04);
    park_go = 0;
    step;
    $display("park test done");
  endtask
  initial begin
    repeat (12) step;
    rst = 0;
    held;
    start(8'h00);
    park;
    held;
    start(8'ha5);
    complete_run;
  end
endmodule
